// [rtl/oled_cmd_pkg.sv]
/*
 Constants shared by both ends of the command link: opcodes, parameter counts,
 reset values, scroll step timing and the host's own register map.
 Assumes one 25 MHz clock common to both ends.
*/
package oled_cmd_pkg;
   // Opcodes
   localparam logic [7:0] OP_TABLE = 8'hB8;
   localparam logic [7:0] OP_LINEAR = 8'hB9;
   localparam logic [7:0] OP_PRECHARGE = 8'hBB;
   localparam logic [7:0] OP_DESELECT = 8'hBE;
   localparam logic [7:0] OP_CONTRAST = 8'hC1;
   localparam logic [7:0] OP_MASTER = 8'hC7;
   localparam logic [7:0] OP_ROWS = 8'hCA;
   localparam logic [7:0] OP_NOP_A = 8'hD1;
   localparam logic [7:0] OP_NOP_B = 8'hE3;
   localparam logic [7:0] OP_LOCK = 8'hFD;
   localparam logic [7:0] OP_SCROLL = 8'h96;
   localparam logic [7:0] OP_SCROLL_STOP = 8'h9E;
   localparam logic [7:0] OP_SCROLL_GO = 8'h9F;
   // Parameter byte counts
   localparam logic [5:0] N_TABLE = 6'h3F;
   localparam logic [5:0] N_CONTRAST = 6'h03;
   localparam logic [5:0] N_SCROLL = 6'h05;
   localparam logic [5:0] N_ONE = 6'h01;
   localparam int TABLE_LEN = 63;
   localparam int TABLE_STEP = 2;
   // Field values and reset values
   localparam logic [7:0] LOCK_ON = 8'h16;
   localparam logic [7:0] LOCK_OFF = 8'h12;
   localparam logic [4:0] PRECHARGE_RST = 5'h17;
   localparam logic [2:0] DESELECT_RST = 3'h5;
   localparam logic [7:0] CONTRAST_A_RST = 8'h8A;
   localparam logic [7:0] CONTRAST_B_RST = 8'h51;
   localparam logic [7:0] CONTRAST_C_RST = 8'h8A;
   localparam logic [3:0] MASTER_RST = 4'hF;
   localparam logic [6:0] ROWS_RST = 7'h7F;
   localparam logic [6:0] ROWS_MIN = 7'h0F;
   localparam logic [7:0] ENTRY_MAX = 8'hB4;
   localparam logic [8:0] ROW_SUM_MAX = 9'h080;
   localparam logic [7:0] SCROLL_TO_ZERO = 8'h40;
   // Scroll step intervals in clock cycles: test, normal, slow, slowest
   localparam logic [15:0] STEP_TEST = 16'h0001;
   localparam logic [15:0] STEP_NORMAL = 16'h0400;
   localparam logic [15:0] STEP_SLOW = 16'h1000;
   localparam logic [15:0] STEP_SLOWEST = 16'h4000;
   // Settle time per pixel after a graphic command
   localparam int CLK_PERIOD_NS = 40;
   localparam int PIXEL_WAIT_NS = 500;
   localparam logic [3:0] PIXEL_WAIT_CYC = 4'((PIXEL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Host register map (byte addresses)
   localparam logic [3:0] REG_SEND = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_WAIT = 4'h8;
   localparam logic [3:0] REG_CLEAR = 4'hC;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Decoder states
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_PARAM = 2'b10} dec_state_type;
endpackage

// [rtl/oled_link_if.sv]
/*
 Command link between host controller and display command decoder.
 Assumes both ends run on ref_clk; strobe marks one byte per cycle.
*/
interface oled_link_if (input wire logic ref_clk);
   logic strobe;
   logic dc;
   logic [7:0] data;
   modport host (output strobe, output dc, output data);
   modport device (input strobe, input dc, input data);
endinterface

// [rtl/oled_cmd_decoder.sv]
/*
 Display driver command decoder: takes command and parameter bytes from the
 link and holds the configuration state, pulse width table and scroll engine.
 Assumes the link comes from logic on ref_clk, one byte per strobe.
*/
module oled_cmd_decoder (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Link from the host
   oled_link_if.device link,
   // Display state from the panel sequencer
   input wire logic display_on,
   input wire logic [5:0] gray_level,
   // Drive timing for the addressed gray level
   output logic [7:0] drive_clocks,
   output logic current_drive,
   // Configuration outputs
   output logic [4:0] precharge_level,
   output logic [2:0] row_deselect_level,
   output logic [7:0] contrast_a,
   output logic [7:0] contrast_b,
   output logic [7:0] contrast_c,
   output logic [3:0] master_contrast,
   output logic [6:0] active_row_count,
   output logic locked,
   // Scroll engine outputs
   output logic scroll_active,
   output logic [6:0] scroll_offset,
   output logic [6:0] scroll_first_row,
   output logic [7:0] scroll_row_total
);
   import oled_cmd_pkg::*;

   dec_state_type state_q;
   logic [7:0] op_q;
   logic [5:0] left_q;
   logic [5:0] idx_q;
   logic locked_q;
   logic [7:0] table_q [TABLE_LEN];
   logic [4:0] precharge_q;
   logic [2:0] deselect_q;
   logic [7:0] con_a_q;
   logic [7:0] con_b_q;
   logic [7:0] con_c_q;
   logic [3:0] master_q;
   logic [6:0] rows_q;
   logic [7:0] dir_q;
   logic [6:0] first_row_q;
   logic [7:0] row_total_q;
   logic [6:0] reserved_q;
   logic [1:0] interval_q;
   logic scroll_on_q;
   logic [15:0] tick_q;
   logic [6:0] offset_q;
   logic [7:0] drive_q;
   logic drive_en_q;
   logic cmd_seen;
   logic cmd_take;
   logic par_take;
   logic [7:0] pbyte;
   logic [15:0] step_len;

   // Parameter count per opcode; zero for opcodes without parameters
   function automatic logic [5:0] param_count(input logic [7:0] op);
      case (op)
         OP_TABLE: param_count = N_TABLE;
         OP_CONTRAST: param_count = N_CONTRAST;
         OP_SCROLL: param_count = N_SCROLL;
         OP_PRECHARGE, OP_DESELECT, OP_MASTER, OP_ROWS, OP_LOCK: param_count = N_ONE;
         default: param_count = '0;
      endcase
   endfunction

   // Command bytes other than the lock opcode die while locked
   assign cmd_seen = link.strobe & ~link.dc;
   assign cmd_take = cmd_seen & (~locked_q | (link.data == OP_LOCK));
   assign par_take = link.strobe & link.dc & (state_q == ST_PARAM);
   assign pbyte = link.data;

   // Command and parameter sequencing
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         op_q <= '0;
         left_q <= '0;
         idx_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cmd_take && param_count(link.data) != '0) begin
                  state_q <= ST_PARAM;
                  op_q <= link.data;
                  left_q <= param_count(link.data);
                  idx_q <= '0;
               end
            end
            ST_PARAM: begin
               if (cmd_seen) begin
                  // A new command cuts short an unfinished parameter list
                  state_q <= (cmd_take && param_count(link.data) != '0) ? ST_PARAM : ST_IDLE;
                  op_q <= link.data;
                  left_q <= param_count(link.data);
                  idx_q <= '0;
               end else if (par_take) begin
                  idx_q <= idx_q + 6'h01;
                  left_q <= left_q - 6'h01;
                  if (left_q == N_ONE) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Interface lock
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         locked_q <= 1'b0;
      end else if (par_take && op_q == OP_LOCK) begin
         if (pbyte == LOCK_ON) begin
            locked_q <= 1'b1;
         end else if (pbyte == LOCK_OFF) begin
            locked_q <= 1'b0;
         end
      end
   end

   // Pulse width table: linear after reset and on the default command
   always_ff @(posedge ref_clk) begin
      if (srst || (cmd_take && link.data == OP_LINEAR)) begin
         for (int i = 0; i < TABLE_LEN; i++) begin
            table_q[i] <= 8'(TABLE_STEP * i);
         end
      end else if (par_take && op_q == OP_TABLE) begin
         table_q[idx_q] <= pbyte;
      end
   end

   // Single and triple parameter settings
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         precharge_q <= PRECHARGE_RST;
         deselect_q <= DESELECT_RST;
         con_a_q <= CONTRAST_A_RST;
         con_b_q <= CONTRAST_B_RST;
         con_c_q <= CONTRAST_C_RST;
         master_q <= MASTER_RST;
         rows_q <= ROWS_RST;
      end else if (par_take) begin
         if (op_q == OP_PRECHARGE) begin
            precharge_q <= pbyte[4:0];
         end else if (op_q == OP_DESELECT) begin
            deselect_q <= pbyte[2:0];
         end else if (op_q == OP_CONTRAST) begin
            if (idx_q == 6'h00) con_a_q <= pbyte;
            if (idx_q == 6'h01) con_b_q <= pbyte;
            if (idx_q == 6'h02) con_c_q <= pbyte;
         end else if (op_q == OP_MASTER) begin
            master_q <= pbyte[3:0];
         end else if (op_q == OP_ROWS && pbyte[6:0] >= ROWS_MIN) begin
            rows_q <= pbyte[6:0];
         end
      end
   end

   // Scroll set-up bytes, in order
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dir_q <= '0;
         first_row_q <= '0;
         row_total_q <= '0;
         reserved_q <= '0;
         interval_q <= '0;
      end else if (par_take && op_q == OP_SCROLL) begin
         case (idx_q)
            6'h00: dir_q <= pbyte;
            6'h01: first_row_q <= pbyte[6:0];
            6'h02: row_total_q <= pbyte;
            6'h03: reserved_q <= pbyte[6:0];
            default: interval_q <= pbyte[1:0];
         endcase
      end
   end

   // Step length for the selected interval
   always_comb begin
      case (interval_q)
         2'b00: step_len = STEP_TEST;
         2'b01: step_len = STEP_NORMAL;
         2'b10: step_len = STEP_SLOW;
         default: step_len = STEP_SLOWEST;
      endcase
   end

   // Start and stop; D1, E3 and unknown opcodes fall through unchanged
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         scroll_on_q <= 1'b0;
      end else if (cmd_take && link.data == OP_SCROLL_GO) begin
         scroll_on_q <= 1'b1;
      end else if (cmd_take && link.data == OP_SCROLL_STOP) begin
         scroll_on_q <= 1'b0;
      end
   end

   // Scroll engine; stop leaves the offset where it stood
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tick_q <= '0;
         offset_q <= '0;
      end else if (scroll_on_q && display_on && dir_q != '0) begin
         if (tick_q >= step_len - 16'h0001) begin
            tick_q <= '0;
            if (dir_q >= SCROLL_TO_ZERO) begin
               offset_q <= offset_q - 7'h01;
            end else begin
               offset_q <= offset_q + 7'h01;
            end
         end else begin
            tick_q <= tick_q + 16'h0001;
         end
      end
   end

   // Drive time for the requested level; level zero never drives
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         drive_q <= '0;
         drive_en_q <= 1'b0;
      end else if (gray_level == 6'h00) begin
         drive_q <= '0;
         drive_en_q <= 1'b0;
      end else begin
         drive_q <= table_q[gray_level - 6'h01];
         drive_en_q <= table_q[gray_level - 6'h01] != '0;
      end
   end

   // Outputs from registers
   assign drive_clocks = drive_q;
   assign current_drive = drive_en_q;
   assign precharge_level = precharge_q;
   assign row_deselect_level = deselect_q;
   assign contrast_a = con_a_q;
   assign contrast_b = con_b_q;
   assign contrast_c = con_c_q;
   assign master_contrast = master_q;
   assign active_row_count = rows_q;
   assign locked = locked_q;
   assign scroll_active = scroll_on_q;
   assign scroll_offset = offset_q;
   assign scroll_first_row = first_row_q;
   assign scroll_row_total = row_total_q;
endmodule

// [rtl/oled_host_ctrl.sv]
/*
 Host side of the command link: an AXI4-Lite slave whose registers let
 software send command and parameter bytes, pace graphic commands and see
 sequence errors. Assumes the decoder shares ref_clk.
*/
module oled_host_ctrl (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // AXI4-Lite slave
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Link to the decoder
   oled_link_if.host link
);
   import oled_cmd_pkg::*;

   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic strobe_q;
   logic dc_q;
   logic [7:0] data_q;
   logic [19:0] wait_q;
   logic [5:0] table_left_q;
   logic [7:0] prev_q;
   logic [2:0] pidx_q;
   logic [7:0] op_q;
   logic [6:0] start_row_q;
   logic entry_err_q;
   logic rows_err_q;
   logic rewrite_q;
   logic wr_take;
   logic send_ok;
   logic busy;
   logic [31:0] status;

   // Write address and data are taken together
   assign wr_take = awvalid & wvalid & ~bvalid_q;
   assign awready = wr_take;
   assign wready = wr_take;
   assign arready = ~rvalid_q;
   assign busy = wait_q != '0;
   assign send_ok = wr_take & (awaddr == REG_SEND) & wstrb[0] & ~busy;
   assign status = {18'h0, table_left_q, 3'h0, rewrite_q, rows_err_q, entry_err_q, table_left_q != '0, busy};

   // Write response
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_take) begin
         bvalid_q <= 1'b1;
         if (awaddr == REG_SEND) begin
            bresp_q <= send_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (awaddr == REG_WAIT || awaddr == REG_CLEAR) begin
            bresp_q <= RESP_OKAY;
         end else begin
            bresp_q <= RESP_SLVERR;
         end
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read channel
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         if (araddr == REG_STATUS) begin
            rdata_q <= status;
            rresp_q <= RESP_OKAY;
         end else begin
            rdata_q <= '0;
            rresp_q <= RESP_SLVERR;
         end
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // One byte onto the link per accepted send
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         strobe_q <= 1'b0;
         dc_q <= 1'b0;
         data_q <= '0;
      end else begin
         strobe_q <= send_ok;
         if (send_ok) begin
            dc_q <= wdata[8];
            data_q <= wdata[7:0];
         end
      end
   end

   // Settle wait after a graphic command, per pixel
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wait_q <= '0;
      end else if (wr_take && awaddr == REG_WAIT) begin
         wait_q <= 20'(wdata[15:0] * PIXEL_WAIT_CYC);
      end else if (busy) begin
         wait_q <= wait_q - 20'h00001;
      end
   end

   // Sequence tracking of sent bytes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         table_left_q <= '0;
         prev_q <= '0;
         pidx_q <= '0;
         op_q <= '0;
         start_row_q <= '0;
      end else if (send_ok && !wdata[8]) begin
         op_q <= wdata[7:0];
         pidx_q <= '0;
         table_left_q <= (wdata[7:0] == OP_TABLE) ? N_TABLE : 6'h00;
      end else if (send_ok) begin
         pidx_q <= pidx_q + 3'h1;
         prev_q <= wdata[7:0];
         if (table_left_q != '0) table_left_q <= table_left_q - 6'h01;
         if (op_q == OP_SCROLL && pidx_q == 3'h1) start_row_q <= wdata[6:0];
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         entry_err_q <= 1'b0;
         rows_err_q <= 1'b0;
         rewrite_q <= 1'b0;
      end else begin
         if (wr_take && awaddr == REG_CLEAR) begin
            if (wdata[2]) entry_err_q <= 1'b0;
            if (wdata[3]) rows_err_q <= 1'b0;
            if (wdata[4]) rewrite_q <= 1'b0;
         end
         if (send_ok && wdata[8] && table_left_q != '0) begin
            if (wdata[7:0] > ENTRY_MAX) entry_err_q <= 1'b1;
            if (table_left_q != N_TABLE && wdata[7:0] <= prev_q) entry_err_q <= 1'b1;
         end
         if (send_ok && wdata[8] && op_q == OP_SCROLL && pidx_q == 3'h2 &&
               ({2'b00, start_row_q} + {1'b0, wdata[7:0]}) > ROW_SUM_MAX) begin
            rows_err_q <= 1'b1;
         end
         if (send_ok && !wdata[8] && wdata[7:0] == OP_SCROLL_STOP) rewrite_q <= 1'b1;
      end
   end

   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign link.strobe = strobe_q;
   assign link.dc = dc_q;
   assign link.data = data_q;
endmodule

// [verif/oled_link_monitor.sv]
/*
 Checker for the command link and the decoder state it drives.
 Assumes one clock, ref_clk, and a synchronous active-high srst.
*/
module oled_link_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Link
   input wire logic strobe,
   input wire logic dc,
   input wire logic [7:0] data,
   // Decoder inputs and outputs
   input wire logic display_on,
   input wire logic [5:0] gray_level,
   input wire logic [7:0] drive_clocks,
   input wire logic current_drive,
   input wire logic [4:0] precharge_level,
   input wire logic [3:0] master_contrast,
   input wire logic [6:0] active_row_count,
   input wire logic locked,
   input wire logic scroll_active,
   input wire logic [6:0] scroll_offset
);
   timeunit 1ns;
   timeprecision 1ns;
   import oled_cmd_pkg::*;
   logic [7:0] pend_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Opcode whose first parameter is still awaited
   always_ff @(posedge ref_clk) begin
      if (srst) pend_q <= 8'h00;
      else if (strobe) pend_q <= dc ? 8'h00 : data;
   end
   sequence s_cmd(logic [7:0] op);
      strobe && !dc && data == op;
   endsequence
   sequence s_arg(logic [7:0] op);
      strobe && dc && pend_q == op && !locked;
   endsequence
   a_precharge_take: assert property (
      s_arg(OP_PRECHARGE) |=> precharge_level == $past(data[4:0])) else $error("precharge not taken");
   a_rows_range: assert property (
      s_arg(OP_ROWS) |=> active_row_count ==
      ($past(data[6:0]) < ROWS_MIN ? $past(active_row_count) : $past(data[6:0]))) else $error("rows wrong");
   a_lock_value: assert property (
      strobe && dc && pend_q == OP_LOCK && (data == LOCK_ON || data == LOCK_OFF)
      |=> locked == ($past(data) == LOCK_ON)) else $error("lock state wrong");
   a_locked_drop: assert property (
      locked && strobe && !(dc && pend_q == OP_LOCK) |=> $stable(precharge_level) &&
      $stable(master_contrast) && $stable(active_row_count) && $stable(scroll_active)) else $error("locked change");
   a_nop_quiet: assert property (
      (s_cmd(OP_NOP_A) or s_cmd(OP_NOP_B)) |=> $stable(precharge_level) &&
      $stable(active_row_count) && $stable(scroll_active)) else $error("nop changed state");
   a_scroll_go: assert property (
      s_cmd(OP_SCROLL_GO) ##0 !locked |=> scroll_active) else $error("scroll not started");
   a_scroll_halt: assert property (
      s_cmd(OP_SCROLL_STOP) ##0 !locked |=> !scroll_active ##1 $stable(scroll_offset)) else $error("scroll not stopped");
   a_level_zero: assert property (
      gray_level == 6'h00 |=> !current_drive && drive_clocks == 8'h00) else $error("level zero drives");
   a_scroll_dark: assert property (
      !display_on |=> $stable(scroll_offset)) else $error("scroll while dark");
endmodule

// [verif/testbench.sv]
/*
 Testbench: host controller and decoder joined by the link, driven over AXI4-Lite.
 Assumes the package constants and a 25 MHz ref_clk.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import oled_cmd_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] awaddr, wstrb, araddr, mc;
   logic awvalid, wvalid, bready, arvalid, rready, display_on, awready, wready, bvalid, arready, rvalid;
   logic current_drive, locked, scroll_active;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [5:0] gray_level;
   logic [7:0] drive_clocks, ca, cb, cc, row_total;
   logic [4:0] pre;
   logic [2:0] desel;
   logic [6:0] rows, offs, first_row;
   logic [7:0] tb [64];
   logic [7:0] dirs [5] = '{8'h00, 8'h01, 8'h3F, 8'h40, 8'hFF};
   int steps [4] = '{STEP_TEST, STEP_NORMAL, STEP_SLOW, STEP_SLOWEST};
   int fails = 0, checked = 0;
   oled_link_if lnk (.ref_clk(ref_clk));
   oled_host_ctrl u_oled_host_ctrl (.ref_clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .link(lnk.host));
   oled_cmd_decoder u_oled_cmd_decoder (.ref_clk, .srst, .link(lnk.device), .display_on, .gray_level,
      .drive_clocks, .current_drive, .precharge_level(pre), .row_deselect_level(desel), .contrast_a(ca),
      .contrast_b(cb), .contrast_c(cc), .master_contrast(mc), .active_row_count(rows), .locked,
      .scroll_active, .scroll_offset(offs), .scroll_first_row(first_row), .scroll_row_total(row_total));
   oled_link_monitor u_mon (.ref_clk, .srst, .strobe(lnk.strobe), .dc(lnk.dc), .data(lnk.data),
      .display_on, .gray_level, .drive_clocks, .current_drive, .precharge_level(pre), .master_contrast(mc),
      .active_row_count(rows), .locked, .scroll_active, .scroll_offset(offs));
   // Clock
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   // Write: address and data offered together, response awaited
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      {awvalid, wvalid, bready} <= 3'h7;
      do @(posedge ref_clk); while (!(awready && wready));
      {awvalid, wvalid} <= 2'h0;
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic send(input logic c, input logic [7:0] b);
      logic [1:0] r;
      wr(REG_SEND, {23'h0, c, b}, 4'hF, r);
      chk("send", RESP_OKAY, r);
   endtask
   task automatic pair(input logic [7:0] op, input logic [7:0] b);
      send(1'b0, op);
      send(1'b1, b);
   endtask
   task automatic lit(input logic v);
      @(posedge ref_clk);
      display_on <= v;
   endtask
   task automatic look(input int g, input logic [7:0] e);
      @(posedge ref_clk);
      gray_level <= 6'(g);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("drive", e, drive_clocks);
      chk("current", g != 0 && e != 0, current_drive);
   endtask
   task automatic scroll(input logic [7:0] dir, input logic [1:0] iv);
      logic [7:0] p [5];
      p = '{dir, 8'h10, 8'h20, 8'h00, {6'h00, iv}};
      send(1'b0, OP_SCROLL);
      foreach (p[k]) send(1'b1, p[k]);
      send(1'b0, OP_SCROLL_GO);
   endtask
   task automatic end_sim;
      $display("Checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (90000) @(posedge ref_clk);
      fails++;
      end_sim;
   end
   // Main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [6:0] o;
      int n;
      {awaddr, wstrb, araddr, wdata, gray_level} = '0;
      {awvalid, wvalid, bready, arvalid, rready, display_on} = '0;
      d = $urandom(32'hAA371DF8);
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      chk("pre", PRECHARGE_RST, pre);
      chk("desel", DESELECT_RST, desel);
      chk("ca", CONTRAST_A_RST, ca);
      chk("cb", CONTRAST_B_RST, cb);
      chk("cc", CONTRAST_C_RST, cc);
      chk("rows", ROWS_RST, rows);
      chk("lock", 0, locked);
      for (int i = 0; i < 64; i++) look(i, i ? 8'(TABLE_STEP * (i - 1)) : 8'h00);
      // Rising random table, first entry zero, top entry at the limit
      tb[1] = 8'h00;
      for (int i = 2; i < 63; i++) tb[i] = tb[i - 1] + 8'(1 + $urandom_range(1));
      tb[63] = ENTRY_MAX;
      send(1'b0, OP_TABLE);
      for (int i = 1; i < 64; i++) send(1'b1, tb[i]);
      send(1'b1, 8'h55);
      for (int i = 1; i < 64; i++) look(i, tb[i]);
      // Out-of-range entry, then a list cut short by a command
      pair(OP_TABLE, 8'hC8);
      pair(OP_NOP_A, 8'h77);
      rd(REG_STATUS, d, r);
      chk("entry err", 1, d[2]);
      wr(REG_CLEAR, 32'h4, 4'hF, r);
      rd(REG_STATUS, d, r);
      chk("entry clr", 0, d[2]);
      look(2, tb[2]);
      send(1'b0, OP_LINEAR);
      for (int i = 1; i < 64; i++) look(i, 8'(TABLE_STEP * (i - 1)));
      // Single and triple parameter commands, rows just below its minimum and at its bounds first
      n = 127;
      for (int j = 0; j < 6; j++) begin
         d = $urandom;
         if (j < 3) d[30:24] = j == 0 ? 7'h0E : j == 1 ? 7'h0F : 7'h7F;
         if (d[30:24] >= ROWS_MIN) n = d[30:24];
         pair(OP_PRECHARGE, {3'h0, d[4:0]});
         pair(OP_DESELECT, {5'h0, d[10:8]});
         pair(OP_MASTER, d[23:16]);
         send(1'b0, OP_CONTRAST);
         for (int i = 0; i < 3; i++) send(1'b1, d[8 * i +: 8]);
         pair(OP_ROWS, {1'b0, d[30:24]});
         @(negedge ref_clk);
         chk("pre", d[4:0], pre);
         chk("desel", d[10:8], desel);
         chk("mc", d[19:16], mc);
         chk("ca", d[7:0], ca);
         chk("cb", d[15:8], cb);
         chk("cc", d[23:16], cc);
         chk("rows", n, rows);
      end
      // No-operations and a stray parameter
      pair(OP_NOP_A, 8'h03);
      send(1'b0, OP_NOP_B);
      @(negedge ref_clk);
      chk("nop pre", d[4:0], pre);
      // Lock, blocked commands, bad value, unlock
      pair(OP_LOCK, LOCK_ON);
      pair(OP_PRECHARGE, 8'h00);
      send(1'b0, OP_SCROLL_GO);
      pair(OP_LOCK, 8'h33);
      @(negedge ref_clk);
      chk("locked", 1, locked);
      chk("lk pre", d[4:0], pre);
      chk("lk scr", 0, scroll_active);
      pair(OP_LOCK, LOCK_OFF);
      pair(OP_PRECHARGE, 8'h1F);
      @(negedge ref_clk);
      chk("unlk pre", 5'h1F, pre);
      // Scroll directions, dark then lit
      for (int i = 0; i < 5; i++) begin
         scroll(dirs[i], 2'b00);
         @(negedge ref_clk);
         chk("act", 1, scroll_active);
         chk("first", 7'h10, first_row);
         chk("total", 8'h20, row_total);
         o = offs;
         repeat (6) @(negedge ref_clk);
         chk("dark", o, offs);
         lit(1'b1);
         repeat (6) @(negedge ref_clk);
         n = offs == o ? 0 : 7'(offs - o) < 7'h40 ? 1 : 2;
         chk("dir", dirs[i] == 8'h00 ? 0 : dirs[i] < SCROLL_TO_ZERO ? 1 : 2, n);
         send(1'b0, OP_SCROLL_STOP);
         @(negedge ref_clk);
         o = offs;
         chk("stop", 0, scroll_active);
         repeat (4) @(negedge ref_clk);
         chk("held", o, offs);
         lit(1'b0);
      end
      rd(REG_STATUS, d, r);
      chk("rewrite", 1, d[4]);
      // Step interval for each timing code
      foreach (steps[i]) begin
         scroll(8'h01, 2'(i));
         lit(1'b1);
         @(negedge ref_clk);
         // First pass finds a step, second times a whole interval
         for (int k = 0; k < 2; k++) begin
            o = offs;
            n = 0;
            do begin
               @(negedge ref_clk);
               n++;
            end while (offs === o && n < 20000);
         end
         chk("step", steps[i], n);
         send(1'b0, OP_SCROLL_STOP);
         lit(1'b0);
      end
      // Pacing after a graphic command, refused and unmapped accesses
      wr(REG_WAIT, 32'h2, 4'hF, r);
      wr(REG_SEND, {24'h0, OP_NOP_A}, 4'hF, r);
      chk("busy send", RESP_SLVERR, r);
      rd(REG_STATUS, d, r);
      chk("busy", 1, d[0]);
      repeat (30) @(posedge ref_clk);
      rd(REG_STATUS, d, r);
      chk("idle", 0, d[0]);
      wr(REG_SEND, {24'h0, OP_NOP_A}, 4'h0, r);
      chk("strobe", RESP_SLVERR, r);
      rd(REG_WAIT, d, r);
      chk("unmapped resp", RESP_SLVERR, r);
      chk("unmapped data", 0, d);
      end_sim;
   end
endmodule
